// [pkg/cmp_pkg.sv]
// shared constants, register map and carrier types of the complementary pwm block
package cmp_pkg;

  // ---------------------------------------------------------------------------
  // structure
  // ---------------------------------------------------------------------------
  localparam int CMP_CNT_W     = 16;
  localparam int CMP_NUM_LEGS  = 3;
  localparam int CMP_NUM_SIDES = 6;
  localparam int CMP_NUM_CH    = 8;
  localparam int CMP_ADDR_W    = 12;

  // channel bit positions in start, stop and running words
  localparam int CMP_CH_MASTER = 0;
  localparam int CMP_CH_THIN   = 1;
  localparam int CMP_CH_LEG0   = 2;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_START   = 12'h000;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_STOP    = 12'h004;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_RUNNING = 12'h008;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_PERIOD  = 12'h00C;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_THIN    = 12'h010;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DUTY0   = 12'h014;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DUTY1   = 12'h018;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DUTY2   = 12'h01C;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DEAD0   = 12'h020;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DEAD1   = 12'h024;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_DEAD2   = 12'h028;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_OUTCTL  = 12'h02C;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_STATUS  = 12'h030;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_MCOUNT  = 12'h034;
  localparam logic [CMP_ADDR_W-1:0] CMP_OFS_TCOUNT  = 12'h038;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CMP_OCTL_LVL_LSB = 0;
  localparam int CMP_OCTL_MOD_LSB = 8;
  localparam int CMP_OCTL_POL_LSB = 16;
  localparam int CMP_STAT_PIN_LSB = 0;
  localparam int CMP_STAT_LVL_LSB = 8;
  localparam int CMP_STAT_UP_BIT  = 16;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam int CMP_RST_PERIOD = 255;
  localparam int CMP_RST_THIN   = 1;
  localparam int CMP_RST_DUTY   = 0;
  localparam int CMP_RST_DEAD   = 0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMP_PH_UP   = 2'b01,
    CMP_PH_DOWN = 2'b10
  } cmp_phase_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [CMP_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } cmp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } cmp_apb_rsp_t;

  typedef struct packed {
    logic duty_start;
    logic dead_start;
    logic duty_stop;
    logic dead_stop;
    logic period_event;
    logic up_phase;
  } cmp_leg_ctl_t;

  typedef struct packed {
    logic duty_running;
    logic dead_running;
    logic duty_event;
    logic dead_event;
    logic duty_active;
    logic partner_active;
  } cmp_leg_out_t;

  // true for every offset that the slave answers
  function automatic logic cmp_addr_ok(input logic [CMP_ADDR_W-1:0] addr);
    cmp_addr_ok = (addr[1:0] == 2'h0) && (addr <= CMP_OFS_TCOUNT);
  endfunction : cmp_addr_ok

endpackage : cmp_pkg

// [rtl/cmp_rst_sync.sv]
// two-stage synchroniser that releases the active-low reset on the clock
`timescale 1ns/1ps
`default_nettype none
module cmp_rst_sync (
  input  wire logic clock,
  input  wire logic resetn,
  output logic      resetn_sync
);
  import cmp_pkg::*;

  typedef struct packed {
    logic [1:0] stage;
  } cmp_sync_state_t;

  cmp_sync_state_t st;
  cmp_sync_state_t next_st;

  // shift a one in; assertion is immediate, release takes two edges
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[0], 1'b1};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign resetn_sync = st.stage[1];

endmodule : cmp_rst_sync
`default_nettype wire

// [rtl/cmp_leg.sv]
// one phase leg: up/down duty channel plus one-count dead-time channel
`timescale 1ns/1ps
`default_nettype none
module cmp_leg #(
  parameter int CNT_W = cmp_pkg::CMP_CNT_W
) (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire cmp_pkg::cmp_leg_ctl_t ctl,
  input  wire logic [CNT_W-1:0]     period_value,
  input  wire logic [CNT_W-1:0]     duty_value,
  input  wire logic [CNT_W-1:0]     deadtime_value,
  output cmp_pkg::cmp_leg_out_t     leg_out
);
  import cmp_pkg::*;

  typedef struct packed {
    logic             duty_run;
    logic             dead_run;
    logic             counting;
    logic             hit_done;
    logic [CNT_W-1:0] duty_counter;
    logic             raw;
    logic             dead_busy;
    logic [CNT_W-1:0] deadtime_counter;
  } cmp_leg_state_t;

  cmp_leg_state_t st;
  cmp_leg_state_t next_st;
  logic           duty_hit;
  logic           dead_end;

  // one crossing per half period; hit_done stops repeats while saturated
  assign duty_hit = st.counting & ~st.hit_done & (st.duty_counter == duty_value) &
                    (duty_value != '0);
  assign dead_end = st.dead_busy & (st.deadtime_counter <= CNT_W'(1));

  // duty counter, output toggle and dead-time count
  always_comb begin
    next_st = st;
    if (ctl.duty_start) begin
      next_st.duty_run = 1'b1;
      next_st.counting = 1'b0;
    end
    if (ctl.dead_start) begin
      next_st.dead_run = 1'b1;
    end
    if (st.duty_run & ctl.period_event) begin
      next_st.counting     = 1'b1;
      next_st.hit_done     = 1'b0;
      next_st.duty_counter = ctl.up_phase ? '0 : period_value;
      if (!st.counting) begin
        next_st.raw = 1'b1;
      end
    end else if (st.counting) begin
      if (ctl.up_phase && st.duty_counter < period_value) begin
        next_st.duty_counter = st.duty_counter + CNT_W'(1);
      end else if (!ctl.up_phase && st.duty_counter != '0) begin
        next_st.duty_counter = st.duty_counter - CNT_W'(1);
      end
    end
    if (duty_hit) begin
      next_st.raw      = ~st.raw;
      next_st.hit_done = 1'b1;
    end
    // one-count mode: each duty event loads and runs the dead time once
    if (duty_hit && st.dead_run && deadtime_value != '0) begin
      next_st.dead_busy        = 1'b1;
      next_st.deadtime_counter = deadtime_value;
    end else if (st.dead_busy) begin
      if (dead_end) begin
        next_st.dead_busy = 1'b0;
      end else begin
        next_st.deadtime_counter = st.deadtime_counter - CNT_W'(1);
      end
    end
    if (ctl.duty_stop) begin
      next_st.duty_run = 1'b0;
      next_st.counting = 1'b0;
    end
    if (ctl.dead_stop) begin
      next_st.dead_run  = 1'b0;
      next_st.dead_busy = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // both sides idle while the dead time runs, so a leg never shoots through
  assign leg_out = '{
    duty_running:   st.duty_run,
    dead_running:   st.dead_run,
    duty_event:     duty_hit,
    dead_event:     dead_end,
    duty_active:    st.counting & st.raw & ~st.dead_busy,
    partner_active: st.counting & ~st.raw & ~st.dead_busy
  };

endmodule : cmp_leg
`default_nettype wire

// [rtl/cmp_top.sv]
// top of the complementary modulation pwm block with its apb register file
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - channel 0 period, even duty, odd dead time
// - master counts interval, event every period
// - channel 1 thins period events into trigger
// - duty channels count up and down
// - dead-time channels run one count
// - count events toggle pins, six phases
// - modulation on: pwm phase picked by level and polarity
// - modulation off: pin shows stored level
// - channels two-three, four-five, six-seven pair
// - level1/pol0 duty, level0/pol1 partner: complementary
// - reversed settings swap the two phases
// - cleared level falls at next trigger
// - start bits written together, self-clearing
// - master start raises event, starting slaves
module cmp_top #(
  parameter int CNT_W = cmp_pkg::CMP_CNT_W
) (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire cmp_pkg::cmp_apb_req_t  apb_req,
  output cmp_pkg::cmp_apb_rsp_t       apb_rsp,
  output logic [2:0]                  duty_side_pin,
  output logic [2:0]                  deadtime_side_pin,
  output logic                        period_event,
  output logic                        rt_trigger_event,
  output logic [2:0]                  duty_count_event,
  output logic [2:0]                  deadtime_count_event
);
  import cmp_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // counters are read back in the low bits of a 32-bit word
  if (CNT_W < 2 || CNT_W > 24) begin : g_bad_width
    $error("cmp_top: CNT_W must lie between 2 and 24");
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                                master_run;
    logic                                thin_run;
    logic [CNT_W-1:0]                    master_counter;
    cmp_phase_t                          phase;
    logic                                period_ev;
    logic [CNT_W-1:0]                    thin_counter;
    logic                                rt_ev;
    logic [CNT_W-1:0]                    master_period_value;
    logic [CNT_W-1:0]                    thin_value;
    logic [CMP_NUM_LEGS-1:0][CNT_W-1:0]  duty_value;
    logic [CMP_NUM_LEGS-1:0][CNT_W-1:0]  deadtime_value;
    logic [CMP_NUM_SIDES-1:0]            level_shadow;
    logic [CMP_NUM_SIDES-1:0]            level_active;
    logic [CMP_NUM_SIDES-1:0]            mod_enable;
    logic [CMP_NUM_SIDES-1:0]            polarity;
    logic [CMP_NUM_SIDES-1:0]            pins;
    logic [31:0]                         prdata;
  } cmp_top_state_t;

  cmp_top_state_t                    st;
  cmp_top_state_t                    next_st;
  logic                              resetn_sync;
  logic                              wr_en;
  logic                              rd_setup;
  logic [CMP_NUM_CH-1:0]             start_vec;
  logic [CMP_NUM_CH-1:0]             stop_vec;
  logic [CMP_NUM_CH-1:0]             running_vec;
  logic [CNT_W-1:0]                  thin_load;
  cmp_leg_ctl_t [CMP_NUM_LEGS-1:0]   leg_ctl;
  cmp_leg_out_t [CMP_NUM_LEGS-1:0]   leg_out;

  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  cmp_rst_sync u_rst_sync (
    .clock       (clock),
    .resetn      (resetn),
    .resetn_sync (resetn_sync)
  );

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  // writes land on the access edge; reads are fetched in the setup cycle
  assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  // start bits are never stored, so they read back zero: a one-shot trigger
  // a start aimed at a running channel is dropped to keep its count intact
  assign start_vec = (wr_en && apb_req.paddr == CMP_OFS_START) ?
                     (apb_req.pwdata[CMP_NUM_CH-1:0] & ~running_vec) :
                     '0;
  assign stop_vec  = (wr_en && apb_req.paddr == CMP_OFS_STOP) ?
                     apb_req.pwdata[CMP_NUM_CH-1:0] : '0;

  // zero thinning would never fire; treat it as every period
  assign thin_load = (st.thin_value == '0) ? CNT_W'(1) : st.thin_value;

  // zero-wait slave; unmapped or unaligned offsets answer with an error
  assign apb_rsp = '{
    pready:  1'b1,
    prdata:  st.prdata,
    pslverr: apb_req.psel & apb_req.penable & ~cmp_addr_ok(apb_req.paddr)
  };

  assign running_vec[CMP_CH_MASTER] = st.master_run;
  assign running_vec[CMP_CH_THIN]   = st.thin_run;

  // ---------------------------------------------------------------------------
  // phase legs
  // ---------------------------------------------------------------------------
  for (genvar k = 0; k < CMP_NUM_LEGS; k++) begin : g_leg
    // even channel counts the duty, the odd one beside it the dead time
    assign leg_ctl[k] = '{
      duty_start:   start_vec[CMP_CH_LEG0 + 2*k],
      dead_start:   start_vec[CMP_CH_LEG0 + 2*k + 1],
      duty_stop:    stop_vec[CMP_CH_LEG0 + 2*k],
      dead_stop:    stop_vec[CMP_CH_LEG0 + 2*k + 1],
      period_event: st.period_ev,
      up_phase:     (st.phase == CMP_PH_UP)
    };

    cmp_leg #(
      .CNT_W (CNT_W)
    ) u_leg (
      .clock          (clock),
      .resetn         (resetn_sync),
      .ctl            (leg_ctl[k]),
      .period_value   (st.master_period_value),
      .duty_value     (st.duty_value[k]),
      .deadtime_value (st.deadtime_value[k]),
      .leg_out        (leg_out[k])
    );

    assign running_vec[CMP_CH_LEG0 + 2*k]     = leg_out[k].duty_running;
    assign running_vec[CMP_CH_LEG0 + 2*k + 1] = leg_out[k].dead_running;
    assign duty_side_pin[k]                   = st.pins[2*k];
    assign deadtime_side_pin[k]               = st.pins[2*k + 1];
    assign duty_count_event[k]                = leg_out[k].duty_event;
    assign deadtime_count_event[k]            = leg_out[k].dead_event;
  end

  assign period_event     = st.period_ev;
  assign rt_trigger_event = st.rt_ev;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] rd_word;
    logic        pos;
    logic        rev;
    rd_word = '0;
    pos     = 1'b0;
    rev     = 1'b0;
    next_st = st;

    // master: interval count down, event on start and on every wrap
    next_st.period_ev = 1'b0;
    if (start_vec[CMP_CH_MASTER]) begin
      next_st.master_run     = 1'b1;
      next_st.master_counter = st.master_period_value;
      next_st.phase          = CMP_PH_UP;
      next_st.period_ev      = 1'b1;
    end else if (st.master_run) begin
      if (st.master_counter == '0) begin
        next_st.master_counter = st.master_period_value;
        next_st.period_ev      = 1'b1;
        next_st.phase          = (st.phase == CMP_PH_UP) ? CMP_PH_DOWN : CMP_PH_UP;
      end else begin
        next_st.master_counter = st.master_counter - CNT_W'(1);
      end
    end
    if (stop_vec[CMP_CH_MASTER]) begin
      next_st.master_run = 1'b0;
    end

    // channel 1: event counter over period events, reloads on each trigger
    next_st.rt_ev = 1'b0;
    if (start_vec[CMP_CH_THIN]) begin
      next_st.thin_run     = 1'b1;
      next_st.thin_counter = thin_load;
    end else if (st.thin_run && st.period_ev) begin
      if (st.thin_counter <= CNT_W'(1)) begin
        next_st.rt_ev        = 1'b1;
        next_st.thin_counter = thin_load;
      end else begin
        next_st.thin_counter = st.thin_counter - CNT_W'(1);
      end
    end
    if (stop_vec[CMP_CH_THIN]) begin
      next_st.thin_run = 1'b0;
    end

    // written levels take effect only at the trigger, so pins stay put
    if (st.rt_ev) begin
      next_st.level_active = st.level_shadow;
    end

    // pin choice per side: pwm phase picked by level and polarity, or the stored level with modulation off
    for (int s = 0; s < CMP_NUM_SIDES; s++) begin
      pos = leg_out[s/2].duty_active;
      rev = leg_out[s/2].partner_active;
      if (st.mod_enable[s]) begin
        // level 1 gives positive phase, level 0 with polarity 1 reverse
        next_st.pins[s] = st.level_active[s] ? pos : (st.polarity[s] & rev);
      end else begin
        next_st.pins[s] = st.level_active[s];
      end
    end

    // register writes
    if (wr_en) begin
      unique case (apb_req.paddr)
        CMP_OFS_PERIOD: next_st.master_period_value = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_THIN:   next_st.thin_value          = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DUTY0:  next_st.duty_value[0]       = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DUTY1:  next_st.duty_value[1]       = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DUTY2:  next_st.duty_value[2]       = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DEAD0:  next_st.deadtime_value[0]   = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DEAD1:  next_st.deadtime_value[1]   = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_DEAD2:  next_st.deadtime_value[2]   = apb_req.pwdata[CNT_W-1:0];
        CMP_OFS_OUTCTL: begin
          next_st.level_shadow = apb_req.pwdata[CMP_OCTL_LVL_LSB +: CMP_NUM_SIDES];
          next_st.mod_enable   = apb_req.pwdata[CMP_OCTL_MOD_LSB +: CMP_NUM_SIDES];
          next_st.polarity     = apb_req.pwdata[CMP_OCTL_POL_LSB +: CMP_NUM_SIDES];
        end
        default: ;
      endcase
    end

    // read mux, sampled in the setup cycle and held for the access edge
    unique case (apb_req.paddr)
      CMP_OFS_RUNNING: rd_word[CMP_NUM_CH-1:0] = running_vec;
      CMP_OFS_PERIOD:  rd_word[CNT_W-1:0]      = st.master_period_value;
      CMP_OFS_THIN:    rd_word[CNT_W-1:0]      = st.thin_value;
      CMP_OFS_DUTY0:   rd_word[CNT_W-1:0]      = st.duty_value[0];
      CMP_OFS_DUTY1:   rd_word[CNT_W-1:0]      = st.duty_value[1];
      CMP_OFS_DUTY2:   rd_word[CNT_W-1:0]      = st.duty_value[2];
      CMP_OFS_DEAD0:   rd_word[CNT_W-1:0]      = st.deadtime_value[0];
      CMP_OFS_DEAD1:   rd_word[CNT_W-1:0]      = st.deadtime_value[1];
      CMP_OFS_DEAD2:   rd_word[CNT_W-1:0]      = st.deadtime_value[2];
      CMP_OFS_OUTCTL: begin
        rd_word[CMP_OCTL_LVL_LSB +: CMP_NUM_SIDES] = st.level_shadow;
        rd_word[CMP_OCTL_MOD_LSB +: CMP_NUM_SIDES] = st.mod_enable;
        rd_word[CMP_OCTL_POL_LSB +: CMP_NUM_SIDES] = st.polarity;
      end
      CMP_OFS_STATUS: begin
        rd_word[CMP_STAT_PIN_LSB +: CMP_NUM_SIDES] = st.pins;
        rd_word[CMP_STAT_LVL_LSB +: CMP_NUM_SIDES] = st.level_active;
        rd_word[CMP_STAT_UP_BIT]                   = (st.phase == CMP_PH_UP);
      end
      CMP_OFS_MCOUNT:  rd_word[CNT_W-1:0]      = st.master_counter;
      CMP_OFS_TCOUNT:  rd_word[CNT_W-1:0]      = st.thin_counter;
      default:         rd_word                 = '0;
    endcase
    if (rd_setup) begin
      next_st.prdata = rd_word;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn_sync) begin
    if (!resetn_sync) begin
      st                     <= '0;
      st.phase               <= CMP_PH_UP;
      st.master_period_value <= CNT_W'(CMP_RST_PERIOD);
      st.thin_value          <= CNT_W'(CMP_RST_THIN);
      st.duty_value          <= {CMP_NUM_LEGS{CNT_W'(CMP_RST_DUTY)}};
      st.deadtime_value      <= {CMP_NUM_LEGS{CNT_W'(CMP_RST_DEAD)}};
    end else begin
      st <= next_st;
    end
  end

endmodule : cmp_top
`default_nettype wire

// [dv/cmp_sva.sv]
// concurrent checks on the ports of the complementary pwm top
`timescale 1ns/1ps
`default_nettype none
module cmp_sva (
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire cmp_pkg::cmp_apb_req_t apb_req,
  input wire cmp_pkg::cmp_apb_rsp_t apb_rsp,
  input wire logic                  period_event,
  input wire logic                  rt_trigger_event
);
  import cmp_pkg::*;
  logic acc, bad, go, halt, run;
  // ----------
  // bus decode
  // ----------
  assign acc  = apb_req.psel && apb_req.penable;
  assign bad  = apb_req.paddr > CMP_OFS_TCOUNT || apb_req.paddr[1:0] != 2'h0;
  assign go   = acc && apb_req.pwrite && apb_req.paddr == CMP_OFS_START && apb_req.pwdata[0];
  assign halt = acc && apb_req.pwrite && apb_req.paddr == CMP_OFS_STOP && apb_req.pwdata[0];
  // master run state as seen from the bus; stop wins over start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run <= 1'b0;
    end else if (halt || go) begin
      run <= !halt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_ready; acc |-> apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_err_set; acc && bad |-> apb_rsp.pslverr; endproperty
  a_err_set: assert property (p_err_set) else $error("unmapped access not refused");
  property p_err_only; apb_rsp.pslverr |-> acc && bad; endproperty
  a_err_only: assert property (p_err_only) else $error("spurious slave error");
  property p_per_pulse; period_event |=> !period_event; endproperty
  a_per_pulse: assert property (p_per_pulse) else $error("period event too long");
  property p_per_run; period_event |-> run || $past(run); endproperty
  a_per_run: assert property (p_per_run) else $error("period event while stopped");
  property p_start; go && !run |=> period_event; endproperty
  a_start: assert property (p_start) else $error("no period event on start");
  property p_trig_src; rt_trigger_event |-> $past(period_event); endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger without period event");
  property p_trig_pulse; rt_trigger_event |=> !rt_trigger_event; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  c_trig: cover property (rt_trigger_event);
  c_err: cover property (acc && bad);
  c_start: cover property (go && !run ##1 period_event);
endmodule : cmp_sva
`default_nettype wire

// [dv/cmp_gate_model.sv]
// gate driver model of the three inverter legs
`timescale 1ns/1ps
`default_nettype none
module cmp_gate_model (
  input  wire logic       clock,
  input  wire logic [2:0] duty_side_pin,
  input  wire logic [2:0] deadtime_side_pin,
  output logic      [5:0] rose,
  output logic            shoot
);
  logic [5:0] last;
  initial {rose, shoot, last} = '0;
  // sticky records; both switches of one leg on would short the supply
  always @(posedge clock) begin
    rose  <= rose | (~last & {duty_side_pin, deadtime_side_pin});
    last  <= {duty_side_pin, deadtime_side_pin};
    shoot <= shoot | (|(duty_side_pin & deadtime_side_pin));
  end
endmodule : cmp_gate_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the complementary pwm top
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import cmp_pkg::*;
  logic         clock = 1'b0, resetn = 1'b0, err, mon = 1'b0, shoot, pev, rtev;
  cmp_apb_req_t req = '0;
  cmp_apb_rsp_t rsp;
  logic [2:0]   dpin, tpin, dev, tev;
  logic [5:0]   rose, evs = '0;
  logic [31:0]  rd;
  logic [11:0]  ra [6] = '{CMP_OFS_PERIOD, CMP_OFS_THIN, CMP_OFS_DUTY1, CMP_OFS_DEAD2,
                         CMP_OFS_OUTCTL, CMP_OFS_RUNNING};
  int           rv [6] = '{CMP_RST_PERIOD, CMP_RST_THIN, 0, 0, 0, 0};
  int           fails = 0, n_compared = 0, cyc = 0, gap, npe, per, thin, seed;
  cmp_top cmp_top_inst (.clock(clock), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .duty_side_pin(dpin), .deadtime_side_pin(tpin), .period_event(pev),
    .rt_trigger_event(rtev), .duty_count_event(dev), .deadtime_count_event(tev));
  cmp_gate_model cmp_gate_model_inst (.clock(clock), .duty_side_pin(dpin),
    .deadtime_side_pin(tpin), .rose(rose), .shoot(shoot));
  always #4 clock = ~clock;
  // ---------------------------------
  // timeout, period and thinning watch
  // ---------------------------------
  always @(posedge clock) begin
    cyc++;
    gap++;
    // sticky record of duty and dead-time count pulses per leg
    evs |= {dev, tev};
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
    if (mon && pev) begin
      if (gap > 0) `CHK("period gap", per + 1, gap)
      gap = 0;
      npe++;
    end
    if (mon && rtev) begin
      `CHK("thinned events", thin, npe)
      npe = 0;
    end
  end
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (rsp.pready !== 1'b1) @(posedge clock);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wait_trig();
    @(posedge clock);
    while (rtev !== 1'b1) @(posedge clock);
  endtask : wait_trig
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // main sequence: reset values, refusal, then a corner run and a random run
  initial begin
    seed = $urandom(32'h234B809D);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], '0);
      `CHK("reset value", rv[i], rd)
    end
    apb(1'b0, 12'h03C, '0);
    `CHK("unmapped error", 1'b1, err)
    for (int r = 0; r < 2; r++) begin
      per = r ? 8 + $urandom % 4 : 8;
      thin = r ? 1 + 2 * ($urandom % 3) : 1;
      apb(1'b1, CMP_OFS_PERIOD, per);
      apb(1'b1, CMP_OFS_THIN, thin);
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, 12'(CMP_OFS_DUTY0 + 4 * k), r ? 1 + $urandom % (per - 4) : 1);
        apb(1'b1, 12'(CMP_OFS_DEAD0 + 4 * k), r ? 1 + $urandom % 2 : 1);
      end
      apb(1'b1, CMP_OFS_OUTCTL, 32'h0006_0F19);
      gap = -100000;
      npe = 0;
      mon = 1'b1;
      apb(1'b1, CMP_OFS_START, 32'h0000_00FF);
      apb(1'b0, CMP_OFS_START, '0);
      `CHK("start self clear", 32'h0, rd)
      apb(1'b0, CMP_OFS_RUNNING, '0);
      `CHK("running flags", 32'hFF, rd)
      repeat (3) wait_trig();
      `CHK("static leg pins", 2'b01, {tpin[2], dpin[2]})
      // polarity kept while pins may be active; written right after a trigger
      apb(1'b1, CMP_OFS_OUTCTL, 32'h0006_0000);
      `CHK("level held until trigger", 1'b1, dpin[2])
      wait_trig();
      repeat (3) @(posedge clock);
      `CHK("pins after cleared level", 6'h0, {dpin, tpin})
      mon = 1'b0;
      apb(1'b1, CMP_OFS_STOP, 32'h0000_00FF);
      apb(1'b0, CMP_OFS_RUNNING, '0);
      `CHK("stopped flags", 32'h0, rd)
    end
    `CHK("count events", 6'h3F, evs)
    `CHK("pins modulated", 6'b111011, rose)
    `CHK("leg overlap", 1'b0, shoot)
    print_verdict();
  end
endmodule : testbench
bind cmp_top cmp_sva cmp_sva_inst (.clock(clock), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .period_event(period_event), .rt_trigger_event(rt_trigger_event));
`default_nettype wire
